// >>> power_startup_protection_sequencer_bench.sv
// self-checking bench for the start-up and protection sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t %h %h", $time, a, e); end end
`define WT(c) begin for (k = 0; k < 5000 && (c) !== 1'b1; k++) @(posedge clk); if ((c) !== 1'b1) begin err_total++; complete_run; end end
module power_startup_protection_sequencer_bench import pss_pkg::*;;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0]  adr = '0;
    logic [3:0]  sel = 4'h1;
    logic [31:0] dat = '0, rd, rdat;
    logic        hv_min = 1, hv_safe = 1, line = 1, t_hi = 0, t_lo = 0;
    logic        latch = 0, burst = 0, low_side = 0, load = 0;
    logic        src, lim, fdis, greg, lreg, undervoltage_lockout_enable, rdy, pfc, llc, fclk;
    pss_cmp_t    cmp;
    int          err_total = 0, n_compared = 0, k;
    logic [31:0] exp_q[$], msk_q[$];

    pss_sequencer #(.T1_CYC(20), .T2_CYC(30), .T3_CYC(10)) u_dut (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack),
        .HIGH_VOLTAGE_PIN_ABOVE_MIN_I(hv_min), .HIGH_VOLTAGE_PIN_ABOVE_SAFE_I(hv_safe),
        .LINE_PRESENT_I(line), .RAIL_ABOVE_SHORT_I(cmp.rail_short),
        .RAIL_ABOVE_STARTUP_I(cmp.rail_startup), .RAIL_ABOVE_FIRST_UV_I(cmp.rail_uv1),
        .RAIL_ABOVE_RESET_I(cmp.rail_rst), .RAIL_ABOVE_RESET_HYS_I(cmp.rail_rst_hys),
        .REG_ABOVE_TURN_ON_I(cmp.reg_on), .REG_ABOVE_UV_I(cmp.reg_uv), .TEMP_ABOVE_HIGH_I(t_hi),
        .TEMP_ABOVE_LOW_I(t_lo), .LATCH_FAULT_I(latch), .BURST_OFF_I(burst),
        .LOW_SIDE_ACTIVE_I(low_side), .STARTUP_SRC_EN_O(src), .STARTUP_LIMITED_CURRENT_O(lim),
        .RAIL_FAST_DISCHARGE_O(fdis), .GATE_DRIVE_REGULATOR_EN_O(greg),
        .LOGIC_SUPPLY_REGULATOR_EN_O(lreg), .UNDERVOLTAGE_LOCKOUT_ENABLE_O(undervoltage_lockout_enable),
        .CORE_READY_O(rdy), .PFC_RUN_O(pfc), .LLC_RUN_O(llc), .CLK_FAST_SEL_O(fclk));
    pss_analog_model u_model (.clk_i(clk), .src_en_i(src), .limited_i(lim),
        .drain_i(load | fdis), .greg_en_i(greg), .cmp_o(cmp));

    always #5 clk = ~clk;
    always @(posedge clk) low_side <= 1'($urandom);

    // read answers meet the oldest note at the ack edge
    always @(posedge clk) begin
        if (ack === 1'b1 && !we) begin
            `CHK(rd & msk_q[0], exp_q[0] & msk_q[0])
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    task automatic complete_run;
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, e, m);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin
            err_total++;
            complete_run;
        end
        rdat = rd;
        {cyc, stb} <= 2'b00;
    endtask : wb

    // polls status until the discharge sequencer reaches a state
    task automatic wx(input logic [2:0] s);
        for (int n = 0; n < 60; n++) begin
            wb(STATUS_ADDR, 1'b0, '0, '0, '0);
            if (rdat[ST_XCAP_LSB +: 3] === s) return;
        end
        err_total++;
        complete_run;
    endtask : wx

    initial begin
        void'($urandom(32'hcb61));
        @(posedge clk);
        #1;
        `CHK({lim, src, greg, lreg, undervoltage_lockout_enable, rdy, pfc, llc, fclk, fdis}, 10'h200)
        @(posedge clk);
        rst <= 0;
        `WT(src)
        `CHK(lim, 1'b1)
        `WT(!lim)
        `CHK(cmp.rail_short, 1'b1)
        wb(CTRL_ADDR, 1'b0, '0, 32'h3, '1);
        wb(8'h08, 1'b1, $urandom, '0, '0);
        wb(8'h08, 1'b0, '0, '0, '1);
        wb(CTRL_ADDR, 1'b1, '0, '0, '0);
        wb(CTRL_ADDR, 1'b0, '0, '0, '1);
        `WT(lreg)
        `CHK(cmp.rail_rst_hys, 1'b1)
        `WT(greg)
        `CHK({cmp.rail_startup, src}, 2'b10)
        `WT(undervoltage_lockout_enable)
        `CHK({cmp.rail_uv1, cmp.reg_on}, 2'b11)
        for (k = 0; k < 3000 && rdy !== 1'b1; k++) @(posedge clk);
        `CHK(k inside {CORE_DLY_CYC, CORE_DLY_CYC + 1}, 1'b1)
        `CHK({pfc, llc, fclk}, 3'b000)
        wb(CTRL_ADDR, 1'b1, 32'h3, '0, '0);
        `WT(pfc)
        `CHK({cmp.reg_on, fclk}, 2'b11)
        burst <= 1;
        `WT(!llc)
        `CHK({pfc, fclk}, 2'b00)
        burst <= 0;
        `WT(pfc)
        load <= 1;
        `WT(!pfc)
        @(posedge clk);
        `CHK({cmp.rail_uv1, greg}, 2'b00)
        `WT(src)
        load <= 0;
        `WT(greg)
        `CHK(cmp.rail_startup, 1'b1)
        `WT(pfc)
        {t_hi, t_lo} <= 2'b11;
        repeat (4) @(posedge clk);
        `CHK({pfc, llc, greg, lreg, src}, 5'h0)
        t_hi <= 0;
        repeat (20) @(posedge clk);
        `CHK(greg, 1'b0)
        t_lo <= 0;
        `WT(greg)
        `WT(pfc)
        load <= 1;
        `WT(!cmp.rail_uv1)
        {latch, load} <= 2'b10;
        @(posedge clk);
        latch <= 0;
        wb(STATUS_ADDR, 1'b0, '0, {29'h0, M_LATCHED}, 32'h7);
        repeat (40) @(posedge clk);
        wb(STATUS_ADDR, 1'b0, '0, {29'h0, M_LATCHED}, 32'h7);
        load <= 1;
        `WT(!lreg)
        load <= 0;
        `WT(greg)
        `WT(pfc)
        `CHK(src, 1'b0)
        line <= 0;
        wx(X_DISCHARGE);
        `CHK(src, 1'b1)
        wx(X_CHECK);
        `CHK(src, 1'b0)
        line <= 1;
        `WT(!greg)
        `WT(pfc)
        line <= 0;
        wx(X_LONG);
        `CHK(src, 1'b1)
        hv_safe <= 0;
        wx(X_FAST);
        `CHK(fdis, 1'b1)
        complete_run;
    end
endmodule : power_startup_protection_sequencer_bench

// >>> pss_analog_model.sv
// analog side model: rail and regulator voltages with their comparators
`timescale 1ns/1ps
module pss_analog_model
    import pss_pkg::*;
#(
    parameter int RST_DV = 60
) (
    // controls from the sequencer
    input  wire logic clk_i,
    input  wire logic src_en_i,
    input  wire logic limited_i,
    input  wire logic drain_i,
    input  wire logic greg_en_i,
    // comparator flags
    output pss_cmp_t  cmp_o
);
    // tenths of a volt; rail holds when nothing moves it
    int rail = 0;
    int gate_drive_regulator = 0;
    always @(posedge clk_i) begin
        if (drain_i) rail <= (rail > 3) ? rail - 3 : 0;
        else if (src_en_i) rail <= rail + (limited_i ? 1 : 4);
        if (greg_en_i) gate_drive_regulator <= (gate_drive_regulator < 120) ? gate_drive_regulator + 2 : gate_drive_regulator;
        else gate_drive_regulator <= (gate_drive_regulator > 3) ? gate_drive_regulator - 3 : 0;
    end
    always_comb begin
        cmp_o              = '0;
        cmp_o.rail_short   = rail > 12;
        cmp_o.rail_startup = rail > 215;
        cmp_o.rail_uv1     = rail > 113;
        cmp_o.rail_rst     = rail > RST_DV;
        cmp_o.rail_rst_hys = rail > RST_DV + 5;
        cmp_o.reg_on       = gate_drive_regulator > 108;
        cmp_o.reg_uv       = gate_drive_regulator > 82;
    end
endmodule : pss_analog_model

// >>> pss_pkg.sv
// shared constants and types for the power start-up and protection sequencer
package pss_pkg;

    // clock and documented times
    localparam int CLK_PERIOD_NS = 10;
    localparam int T1_DETECT_MS  = 96;
    localparam int T2_LONG_MS    = 144;
    localparam int T3_SHORT_MS   = 48;
    localparam int CORE_DLY_NS   = 20000;
    localparam int NS_PER_MS     = 1000000;
    // least time: round up to whole cycles
    localparam int CORE_DLY_CYC  = (CORE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T1_DETECT_CYC = T1_DETECT_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int T2_LONG_CYC   = T2_LONG_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int T3_SHORT_CYC  = T3_SHORT_MS * (NS_PER_MS / CLK_PERIOD_NS);

    // register map (byte addresses)
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam int CTRL_RUN_EN_BIT  = 0;
    localparam int CTRL_XCAP_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // status field positions
    localparam int ST_MAIN_LSB   = 0;
    localparam int ST_XCAP_LSB   = 4;
    localparam int ST_PFC_BIT    = 8;
    localparam int ST_LLC_BIT    = 9;
    localparam int ST_READY_BIT  = 10;
    localparam int ST_LOGIC_BIT  = 11;
    localparam int ST_GATE_BIT   = 12;
    localparam int ST_SRC_BIT    = 13;

    typedef enum logic [2:0] {
        M_CHARGE    = 3'h0,
        M_RUN       = 3'h1,
        M_UNDERVOLT = 3'h2,
        M_LATCHED   = 3'h3,
        M_THERMAL   = 3'h4
    } pss_main_t;

    typedef enum logic [2:0] {
        X_IDLE      = 3'h0,
        X_DETECT    = 3'h1,
        X_DISCHARGE = 3'h2,
        X_CHECK     = 3'h3,
        X_LONG      = 3'h4,
        X_FAST      = 3'h5
    } pss_xcap_t;

    // sampled comparator flags and converter events
    typedef struct packed {
        logic hv_min;
        logic hv_safe;
        logic line;
        logic rail_short;
        logic rail_startup;
        logic rail_uv1;
        logic rail_rst;
        logic rail_rst_hys;
        logic reg_on;
        logic reg_uv;
        logic temp_high;
        logic temp_low;
        logic latch;
        logic burst;
        logic low_side;
    } pss_cmp_t;

endpackage : pss_pkg

// >>> pss_sequencer.sv
// power start-up, x-cap discharge and protection sequencer with wishbone registers
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module pss_sequencer
    import pss_pkg::*;
#(
    parameter int T1_CYC   = T1_DETECT_CYC,
    parameter int T2_CYC   = T2_LONG_CYC,
    parameter int T3_CYC   = T3_SHORT_CYC,
    parameter int TIMER_W  = 24
) (
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        SYS_RST_I,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // comparator flags
    input  wire logic        HIGH_VOLTAGE_PIN_ABOVE_MIN_I,
    input  wire logic        HIGH_VOLTAGE_PIN_ABOVE_SAFE_I,
    input  wire logic        LINE_PRESENT_I,
    input  wire logic        RAIL_ABOVE_SHORT_I,
    input  wire logic        RAIL_ABOVE_STARTUP_I,
    input  wire logic        RAIL_ABOVE_FIRST_UV_I,
    input  wire logic        RAIL_ABOVE_RESET_I,
    input  wire logic        RAIL_ABOVE_RESET_HYS_I,
    input  wire logic        REG_ABOVE_TURN_ON_I,
    input  wire logic        REG_ABOVE_UV_I,
    input  wire logic        TEMP_ABOVE_HIGH_I,
    input  wire logic        TEMP_ABOVE_LOW_I,
    // converter events
    input  wire logic        LATCH_FAULT_I,
    input  wire logic        BURST_OFF_I,
    input  wire logic        LOW_SIDE_ACTIVE_I,
    // supply controls
    output logic             STARTUP_SRC_EN_O,
    output logic             STARTUP_LIMITED_CURRENT_O,
    output logic             RAIL_FAST_DISCHARGE_O,
    output logic             GATE_DRIVE_REGULATOR_EN_O,
    output logic             LOGIC_SUPPLY_REGULATOR_EN_O,
    output logic             UNDERVOLTAGE_LOCKOUT_ENABLE_O,
    output logic             CORE_READY_O,
    // switching controls
    output logic             PFC_RUN_O,
    output logic             LLC_RUN_O,
    output logic             CLK_FAST_SEL_O
);

    if (T1_CYC < 1 || T2_CYC < 1 || T3_CYC < 1 || T1_CYC >= (1 << TIMER_W) ||
        T2_CYC >= (1 << TIMER_W) || T3_CYC >= (1 << TIMER_W)) begin : g_chk
        $error("pss_sequencer: timer lengths do not fit TIMER_W");
    end

    localparam int CORE_W = $clog2(CORE_DLY_CYC + 1);

    function automatic logic timer_done(input logic [TIMER_W-1:0] cnt, input int lim);
        timer_done = (cnt == TIMER_W'(lim - 1));
    endfunction : timer_done

    // flag sampling
    pss_cmp_t cmp_d;
    pss_cmp_t cmp_q;

    always_comb begin
        cmp_d = '{HIGH_VOLTAGE_PIN_ABOVE_MIN_I, HIGH_VOLTAGE_PIN_ABOVE_SAFE_I, LINE_PRESENT_I,
                  RAIL_ABOVE_SHORT_I, RAIL_ABOVE_STARTUP_I, RAIL_ABOVE_FIRST_UV_I, RAIL_ABOVE_RESET_I,
                  RAIL_ABOVE_RESET_HYS_I, REG_ABOVE_TURN_ON_I, REG_ABOVE_UV_I, TEMP_ABOVE_HIGH_I,
                  TEMP_ABOVE_LOW_I, LATCH_FAULT_I, BURST_OFF_I, LOW_SIDE_ACTIVE_I};
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cmp_q <= '0;
        end else begin
            cmp_q <= cmp_d;
        end
    end

    // register bus
    logic [1:0]  ctrl_d;
    logic [1:0]  ctrl_q;
    logic        ack_d;
    logic [31:0] rdat_d;
    logic [31:0] status;
    pss_main_t   main_q;
    pss_xcap_t   xs_q;

    always_comb begin
        ctrl_d = ctrl_q;
        ack_d  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
        rdat_d = WB_DAT_O;
        if (ack_d) begin
            rdat_d = '0;
            if (WB_ADR_I == CTRL_ADDR) begin
                rdat_d[1:0] = ctrl_q;
                if (WB_WE_I && WB_SEL_I[0]) begin
                    ctrl_d = WB_DAT_I[1:0];
                end
            end else if (WB_ADR_I == STATUS_ADDR) begin
                rdat_d = status;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ctrl_q   <= CTRL_RESET;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            WB_ACK_O <= ack_d;
            WB_DAT_O <= rdat_d;
        end
    end

    // x-cap discharge sequence
    pss_xcap_t          xs_d;
    logic [TIMER_W-1:0] xcnt_d;
    logic [TIMER_W-1:0] xcnt_q;
    logic               line_back;

    always_comb begin
        xs_d      = xs_q;
        xcnt_d    = xcnt_q + TIMER_W'(1);
        line_back = 1'b0;
        case (xs_q)
            X_IDLE: begin
                xcnt_d = '0;
                if (!cmp_q.line) begin
                    xs_d = X_DETECT;
                end
            end
            X_DETECT: begin
                if (cmp_q.line) begin
                    xs_d = X_IDLE;
                end else if (timer_done(xcnt_q, T1_CYC)) begin
                    xs_d   = X_DISCHARGE;
                    xcnt_d = '0;
                end
            end
            X_DISCHARGE: begin
                if (timer_done(xcnt_q, T3_CYC)) begin
                    xs_d   = X_CHECK;
                    xcnt_d = '0;
                end
            end
            X_CHECK: begin
                if (cmp_q.line) begin
                    xs_d      = X_IDLE;
                    line_back = 1'b1;
                end else if (timer_done(xcnt_q, T3_CYC)) begin
                    xs_d   = X_LONG;
                    xcnt_d = '0;
                end
            end
            X_LONG: begin
                if (!cmp_q.hv_safe) begin
                    xs_d = X_FAST;
                end else if (timer_done(xcnt_q, T2_CYC)) begin
                    xs_d = X_IDLE;
                end
            end
            X_FAST: begin
                xcnt_d = '0;
                if (cmp_q.line) begin
                    xs_d = X_IDLE;
                end
            end
            default: begin
                xs_d = X_IDLE;
            end
        endcase
        // disabling the feature abandons any sequence in progress
        if (!ctrl_q[CTRL_XCAP_EN_BIT]) begin
            xs_d      = X_IDLE;
            line_back = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            xs_q   <= X_IDLE;
            xcnt_q <= '0;
        end else begin
            xs_q   <= xs_d;
            xcnt_q <= xcnt_d;
        end
    end

    // main protection state
    pss_main_t main_d;

    always_comb begin
        main_d = main_q;
        case (main_q)
            M_CHARGE: begin
                if (cmp_q.temp_high) begin
                    main_d = M_THERMAL;
                end else if (cmp_q.rail_startup) begin
                    main_d = M_RUN;
                end
            end
            M_RUN: begin
                if (cmp_q.temp_high) begin
                    main_d = M_THERMAL;
                end else if (cmp_q.latch) begin
                    main_d = M_LATCHED;
                end else if (!cmp_q.rail_uv1) begin
                    main_d = M_UNDERVOLT;
                end else if (line_back) begin
                    main_d = M_CHARGE;
                end
            end
            M_UNDERVOLT: begin
                if (cmp_q.temp_high) begin
                    main_d = M_THERMAL;
                end else if (cmp_q.latch) begin
                    main_d = M_LATCHED;
                end else if (cmp_q.rail_startup) begin
                    main_d = M_RUN;
                end
            end
            M_LATCHED: begin
                if (cmp_q.temp_high) begin
                    main_d = M_THERMAL;
                end else if (!cmp_q.rail_rst) begin
                    main_d = M_CHARGE;
                end
            end
            M_THERMAL: begin
                if (!cmp_q.temp_high && (!cmp_q.temp_low || !cmp_q.rail_rst)) begin
                    main_d = M_CHARGE;
                end
            end
            default: begin
                main_d = M_CHARGE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            main_q <= M_CHARGE;
        end else begin
            main_q <= main_d;
        end
    end

    // supplies and switching
    logic              chg_d, chg_q;
    logic              lreg_d, sw_ok_d, sw_ok_q;
    logic              src_d, gate_d, undervoltage_lockout_enable_d, ready_d;
    logic              pfc_d, llc_d, run_ok, hard_stop, xdis;
    logic [CORE_W-1:0] core_cnt_d, core_cnt_q;

    always_comb begin
        // hysteretic charge request between first undervoltage and start-up levels
        chg_d = chg_q;
        if (cmp_q.rail_startup) begin
            chg_d = 1'b0;
        end else if (!cmp_q.rail_uv1) begin
            chg_d = 1'b1;
        end
        xdis  = (xs_q == X_DISCHARGE) || (xs_q == X_LONG);
        // charging pauses during the line check so the pin voltage is read undisturbed
        src_d = cmp_q.hv_min && !cmp_q.temp_low &&
                (xdis || (chg_q && xs_q != X_CHECK));

        lreg_d = LOGIC_SUPPLY_REGULATOR_EN_O;
        if (cmp_q.temp_high || main_q == M_THERMAL) begin
            lreg_d = 1'b0;
        end else if (cmp_q.rail_rst_hys) begin
            lreg_d = 1'b1;
        end else if (!cmp_q.rail_rst) begin
            lreg_d = 1'b0;
        end
        gate_d = (main_q == M_RUN) && !cmp_q.temp_high;
        undervoltage_lockout_enable_d = cmp_q.rail_uv1 && cmp_q.reg_on && LOGIC_SUPPLY_REGULATOR_EN_O;

        core_cnt_d = '0;
        ready_d    = 1'b0;
        if (UNDERVOLTAGE_LOCKOUT_ENABLE_O) begin
            core_cnt_d = core_cnt_q;
            ready_d    = CORE_READY_O;
            if (core_cnt_q == CORE_W'(CORE_DLY_CYC - 1)) begin
                ready_d = 1'b1;
            end else begin
                core_cnt_d = core_cnt_q + CORE_W'(1);
            end
        end

        sw_ok_d = sw_ok_q;
        if (main_q != M_RUN || !cmp_q.reg_uv) begin
            sw_ok_d = 1'b0;
        end else if (cmp_q.reg_on) begin
            sw_ok_d = 1'b1;
        end

        hard_stop = cmp_q.temp_high || cmp_q.latch || main_q == M_THERMAL ||
                    main_q == M_LATCHED;
        run_ok    = main_q == M_RUN && sw_ok_q && CORE_READY_O && ctrl_q[CTRL_RUN_EN_BIT] &&
                    !cmp_q.burst && cmp_q.rail_uv1 && cmp_q.reg_uv && !hard_stop;
        pfc_d     = run_ok;
        // resonant stage winds down at a low-side phase; a hard stop turns it off at once
        llc_d = LLC_RUN_O;
        if (hard_stop) begin
            llc_d = 1'b0;
        end else if (run_ok) begin
            llc_d = 1'b1;
        end else if (cmp_q.low_side) begin
            llc_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            chg_q                         <= 1'b1;
            sw_ok_q                       <= 1'b0;
            core_cnt_q                    <= '0;
            STARTUP_SRC_EN_O              <= 1'b0;
            STARTUP_LIMITED_CURRENT_O     <= 1'b1;
            RAIL_FAST_DISCHARGE_O         <= 1'b0;
            GATE_DRIVE_REGULATOR_EN_O     <= 1'b0;
            LOGIC_SUPPLY_REGULATOR_EN_O   <= 1'b0;
            UNDERVOLTAGE_LOCKOUT_ENABLE_O <= 1'b0;
            CORE_READY_O                  <= 1'b0;
            PFC_RUN_O                     <= 1'b0;
            LLC_RUN_O                     <= 1'b0;
            CLK_FAST_SEL_O                <= 1'b0;
        end else begin
            chg_q                         <= chg_d;
            sw_ok_q                       <= sw_ok_d;
            core_cnt_q                    <= core_cnt_d;
            STARTUP_SRC_EN_O              <= src_d;
            STARTUP_LIMITED_CURRENT_O     <= !cmp_q.rail_short;
            RAIL_FAST_DISCHARGE_O         <= (xs_q == X_FAST);
            GATE_DRIVE_REGULATOR_EN_O     <= gate_d;
            LOGIC_SUPPLY_REGULATOR_EN_O   <= lreg_d;
            UNDERVOLTAGE_LOCKOUT_ENABLE_O <= undervoltage_lockout_enable_d;
            CORE_READY_O                  <= ready_d;
            PFC_RUN_O                     <= pfc_d;
            LLC_RUN_O                     <= llc_d;
            CLK_FAST_SEL_O                <= pfc_d || llc_d;
        end
    end

    always_comb begin
        status                                    = '0;
        status[ST_MAIN_LSB +: 3]                  = main_q;
        status[ST_XCAP_LSB +: 3]                  = xs_q;
        status[ST_PFC_BIT]                        = PFC_RUN_O;
        status[ST_LLC_BIT]                        = LLC_RUN_O;
        status[ST_READY_BIT]                      = CORE_READY_O;
        status[ST_LOGIC_BIT]                      = LOGIC_SUPPLY_REGULATOR_EN_O;
        status[ST_GATE_BIT]                       = GATE_DRIVE_REGULATOR_EN_O;
        status[ST_SRC_BIT]                        = STARTUP_SRC_EN_O;
    end

    // checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_uv_seen;
        main_q == M_RUN && !cmp_q.rail_uv1 && !cmp_q.temp_high && !cmp_q.latch;
    endsequence
    sequence s_uv_off;
        main_q == M_UNDERVOLT ##1 (!GATE_DRIVE_REGULATOR_EN_O && !PFC_RUN_O);
    endsequence
    sequence s_hot_stop;
        (!PFC_RUN_O && !LLC_RUN_O && !LOGIC_SUPPLY_REGULATOR_EN_O) ##1 !GATE_DRIVE_REGULATOR_EN_O;
    endsequence

    property p_src_needs_hv;
        STARTUP_SRC_EN_O |-> $past(cmp_q.hv_min) && !$past(cmp_q.temp_low);
    endproperty
    a_src_needs_hv: assert property (p_src_needs_hv) else $error("source on without pin voltage");

    property p_limit;
        ##1 STARTUP_LIMITED_CURRENT_O == !$past(cmp_q.rail_short);
    endproperty
    a_limit: assert property (p_limit) else $error("wrong start-up current limit");

    property p_charge_stop;
        cmp_q.rail_startup |=> !chg_q ##1 (!STARTUP_SRC_EN_O || $past(xdis));
    endproperty
    a_charge_stop: assert property (p_charge_stop) else $error("source kept charging");

    property p_gate_run;
        GATE_DRIVE_REGULATOR_EN_O |-> $past(main_q) == M_RUN;
    endproperty
    a_gate_run: assert property (p_gate_run) else $error("regulator on outside run");

    property p_uv;
        s_uv_seen |=> s_uv_off;
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage shutdown missed");

    property p_latch_hold;
        main_q == M_LATCHED && cmp_q.rail_rst && !cmp_q.temp_high |=> main_q == M_LATCHED;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch left early");

    property p_start_needs_reg;
        $rose(PFC_RUN_O) |-> $past(sw_ok_q);
    endproperty
    a_start_needs_reg: assert property (p_start_needs_reg) else $error("switching before regulator");

    property p_hot;
        cmp_q.temp_high |=> s_hot_stop;
    endproperty
    a_hot: assert property (p_hot) else $error("thermal shutdown missed");

    property p_core_ready;
        $rose(CORE_READY_O) |-> $past(core_cnt_q) == CORE_W'(CORE_DLY_CYC - 1) && $past(UNDERVOLTAGE_LOCKOUT_ENABLE_O);
    endproperty
    a_core_ready: assert property (p_core_ready) else $error("core ready too early");

    property p_slow_clk;
        (hard_stop |=> !CLK_FAST_SEL_O) and (!PFC_RUN_O && !LLC_RUN_O |-> !CLK_FAST_SEL_O);
    endproperty
    a_slow_clk: assert property (p_slow_clk) else $error("fast clock while idle");

    property p_detect;
        xs_q == X_DETECT && timer_done(xcnt_q, T1_CYC) && !cmp_q.line && ctrl_q[CTRL_XCAP_EN_BIT]
            |=> xs_q == X_DISCHARGE ##1 STARTUP_SRC_EN_O == $past(cmp_q.hv_min && !cmp_q.temp_low);
    endproperty
    a_detect: assert property (p_detect) else $error("discharge did not start");

    property p_fast;
        xs_q == X_FAST |=> RAIL_FAST_DISCHARGE_O;
    endproperty
    a_fast: assert property (p_fast) else $error("fast discharge missing");

endmodule : pss_sequencer
